// ---- verification/cgp_host.sv ----
`timescale 1ns/1ps
`default_nettype none
// host bus model: strobes launched after an edge, held one edge
module cgp_host
(
  input  wire logic        clk,              // bus clock
  input  wire logic [15:0] host_rdata,       // read data
  output logic      [3:0]  host_addr,        // word address
  output logic      [15:0] host_wdata,       // write data
  output logic             host_wr,          // write strobe
  output logic             host_low_word_wr  // low word strobe
);
  initial {host_addr, host_wdata, host_wr, host_low_word_wr} = '0;
  // released data is inverted so a late sample cannot pass
  task wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge clk);
    host_addr  <= a;
    host_wdata <= d;
    host_wr    <= 1'b1;
    @(posedge clk);
    host_wr    <= 1'b0;
    host_wdata <= ~d;
  endtask : wr
  // read data is registered, so taken two edges after the address
  task rd(input logic [3:0] a, output logic [15:0] q);
    @(posedge clk);
    host_addr <= a;
    repeat (2) @(posedge clk);
    q = host_rdata;
  endtask : rd
  task lw;
    @(posedge clk);
    host_low_word_wr <= 1'b1;
    @(posedge clk);
    host_low_word_wr <= 1'b0;
  endtask : lw
endmodule : cgp_host
`default_nettype wire

// ---- verification/tb_channel_gain_profile_main_control.sv ----
`timescale 1ns/1ps
`default_nettype none
module tb_channel_gain_profile_main_control;
  import cgp_pkg::*;
  logic clk = 0, sys_rst = 1, ext_gate = 0, int_gate = 0, hw_update = 0, par_mode = 0, fifo_ovf = 0;
  logic ramp_step = 0, ramp_dir_up = 1, four_ch_real = 0, coarse_tick = 0;
  logic [1:0] chan_id = 0;
  logic [15:0] ramp_gain_in = 16'h4444, sum_re = 16'h1111, sum_im = 16'h2222, fir_iq = 16'h3333;
  logic [3:0] host_addr;
  logic [15:0] host_wdata, host_rdata, ramp_gain, iq_out, chan_out, q;
  logic host_wr, host_low_word_wr, slave_load, transmit_gate, ramp_host_acc, coef_host_acc;
  logic fifo_rd_zero, channel_flush_done, flush_active, chan_reset, sib_run, serial_req_en;
  logic [6:0] ramp_addr;
  logic [2:0] ae_threshold;
  int err_total = 0, samples_checked = 0, fa_n = 0, sl_n = 0, cr_n = 0, f0, n0, n1, n2;
  cgp_ctrl uut (.*);
  cgp_host h (.*);
  always #20 clk = ~clk;
  // pulse and cycle tallies; tests compare deltas
  always @(posedge clk)
  begin
    fa_n += flush_active;
    sl_n += slave_load;
    cr_n += chan_reset;
  end
  task cy(input int n); repeat (n) @(posedge clk); endtask : cy
  task chk(input logic [15:0] s, e);
    samples_checked++;
    if (s !== e)
    begin
      err_total++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask : chk
  task rc(input logic [3:0] a, input logic [15:0] e); h.rd(a, q); chk(q, e); endtask : rc
  task td(input string s); $display("test %s ends", s); endtask : td
  // launch internal gate, count edges until it reaches the channel
  task lat(output int n);
    n = 0;
    int_gate <= 1'b1;
    @(posedge clk);
    while (transmit_gate !== 1'b1 && n < 20)
    begin
      @(posedge clk);
      n++;
    end
    int_gate <= 1'b0;
    cy(10);
  endtask : lat
  task test_done;
    $display("checks %0d mismatches %0d", samples_checked, err_total);
    if (err_total == 0 && samples_checked > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : test_done
  // watchdog well beyond the ~330 cycles the tests take
  initial
  begin
    cy(3000);
    err_total++;
    test_done;
  end
  initial
  begin
    cy(4);
    chk(fifo_rd_zero, 1);
    sys_rst <= 1'b0;
    rc(ADDR_GAIN_RAMP, GAIN_RAMP_RST);
    rc(ADDR_MAIN_CTRL, MAIN_CTRL_RST);
    h.wr(ADDR_GAIN_RAMP, 16'hffff);
    rc(ADDR_GAIN_RAMP, 16'h01ff);
    rc(4'h3, 16'h0000);
    h.wr(ADDR_GAIN_RAMP, 16'h0003);
    repeat (8) begin ramp_step <= 1'b1; cy(1); ramp_step <= 1'b0; cy(1); end
    cy(2);
    chk(16'(ramp_addr), 16'h0003);
    h.wr(ADDR_MAIN_CTRL, 16'h5550);
    rc(ADDR_MAIN_CTRL, 16'h5550);
    ramp_dir_up <= 1'b0;
    repeat (4) begin ramp_step <= 1'b1; cy(1); ramp_step <= 1'b0; cy(1); end
    cy(2);
    chk(16'(ramp_addr), 16'h0003);
    chk(ramp_host_acc, 1);
    chk(coef_host_acc, 1);
    chk(16'(ae_threshold), 16'h0005);
    chk(fifo_rd_zero, 0);
    chk(chan_out, sum_re);
    td("registers");
    four_ch_real <= 1'b1;
    h.wr(ADDR_MAIN_CTRL, 16'h00d0);
    for (int i = 0; i < 4; i++)
    begin
      chan_id <= 2'(i);
      cy(3);
      chk(chan_out, i[0] ? sum_re : sum_im);
    end
    h.wr(ADDR_MAIN_CTRL, 16'h0000);
    cy(20);
    chk(chan_out, 16'h0000);
    chk(fifo_rd_zero, 1);
    chk(channel_flush_done, 1);
    td("output");
    f0 = fa_n;
    n0 = sl_n;
    h.wr(ADDR_MAIN_CTRL, 16'h0001);
    cy(24);
    chk(16'(fa_n - f0), 16'h0010);
    chk(16'(sl_n - n0), 16'h0001);
    chk(serial_req_en, 1);
    h.wr(ADDR_MAIN_CTRL, 16'h0000);
    cy(3);
    chk(serial_req_en, 0);
    td("software enable");
    h.wr(ADDR_MAIN_CTRL, 16'h0820);
    lat(n0);
    h.wr(ADDR_GAIN_RAMP, 16'h0080);
    lat(n1);
    h.wr(ADDR_GAIN_RAMP, 16'h0100);
    lat(n2);
    chk(16'(n0 - n1), 16'h0002);
    chk(n2 < n1, 1);
    ext_gate <= 1'b1;
    cy(6);
    chk(transmit_gate, 0);
    ext_gate <= 1'b0;
    h.wr(ADDR_MAIN_CTRL, 16'h0020);
    f0 = fa_n;
    ext_gate <= 1'b1;
    cy(24);
    chk(transmit_gate, 1);
    chk(16'(fa_n - f0), 16'h0010);
    ext_gate <= 1'b0;
    h.wr(ADDR_MAIN_CTRL, 16'h0024);
    f0 = fa_n;
    ext_gate <= 1'b1;
    cy(24);
    chk(16'(fa_n - f0), 16'h0000);
    ext_gate <= 1'b0;
    h.wr(ADDR_MAIN_CTRL, 16'h0000);
    ext_gate <= 1'b1;
    cy(6);
    chk(transmit_gate, 0);
    ext_gate <= 1'b0;
    td("gate");
    par_mode <= 1'b1;
    for (int i = 0; i < 2; i++)
    begin
      h.wr(ADDR_MAIN_CTRL, i ? 16'h0002 : 16'h0000);
      f0 = cr_n;
      fifo_ovf <= 1'b1;
      cy(1);
      fifo_ovf <= 1'b0;
      cy(5);
      chk(16'(cr_n - f0), i ? 16'h0000 : 16'h0001);
    end
    for (int i = 0; i < 2; i++)
    begin
      h.wr(ADDR_MAIN_CTRL, i ? 16'h0020 : 16'h0000);
      cy(10);
      f0 = sl_n;
      hw_update <= 1'b1;
      cy(1);
      hw_update <= 1'b0;
      cy(5);
      chk(16'(sl_n - f0), i ? 16'h0001 : 16'h0000);
    end
    h.wr(ADDR_MAIN_CTRL, 16'h8000);
    cy(12);
    f0 = sl_n;
    h.lw;
    n0 = 1;
    while (slave_load !== 1'b1 && n0 < 12)
    begin
      @(posedge clk);
      n0++;
    end
    cy(4);
    chk(n0 >= 4 && n0 <= 7, 1);
    chk(16'(sl_n - f0), 16'h0001);
    td("update");
    h.wr(ADDR_MAIN_CTRL, 16'h0000);
    cy(3);
    chk(iq_out, 16'h3333);
    chk(ramp_gain, 16'h4444);
    coarse_tick <= 1'b1;
    cy(1);
    coarse_tick <= 1'b0;
    fir_iq <= 16'h5555;
    h.wr(ADDR_MAIN_CTRL, 16'h6000);
    ramp_gain_in <= 16'h6666;
    cy(3);
    chk(iq_out, 16'h3333);
    chk(ramp_gain, 16'h4444);
    td("datapath");
    fir_iq <= 16'h0000; // gate low with free serial block, source zeroed
    h.wr(ADDR_MAIN_CTRL, 16'h0008);
    cy(2);
    chk(sib_run, 1);
    h.wr(ADDR_MAIN_CTRL, 16'h0000);
    cy(2);
    chk(sib_run, 0);
    td("serial block");
    test_done;
  end
endmodule : tb_channel_gain_profile_main_control
`default_nettype wire

// ---- verilog/cgp_ctrl.sv ----
// Summary of operation
// R1: low latency bit drops two gate stages
// R2: high latency bit bypasses gate alignment
// R3: host pairs short latency with span 3/phase 4
// R4: ramp address never exceeds ramp length outside ramp hold
// R5: masked slave load on sync update only
// R6: immediate mode loads slave after 4 clocks
// R7: ramp hold freezes address, gives host RAM
// R8: host reloads ramp after ramp completes
// R9: delay select adds half sample delay
// R10: coefficient hold gives host coefficient RAMs
// R11: gate source internal or external pin
// R12: three-bit almost-empty threshold for FIFOs
// R13: complex mode swaps sums on channels 0,2
// R14: offline zeroes FIFO reads, flags flush done
// R15: input enable gates hardware gate and update
// R16: output enable clear zeroes channel output
// R17: serial block free-run or gate controlled
// R18: source zeroes data while gate low; not done here, iq_out ignores the gate
// R19: gate rising edge flushes unless disabled
// R20: parallel overflow resets unless disabled
// R21: software enable edge: 16-clock flush, update
// R22: software enable level permits serial requests
// R23: low word write strobes immediate load
// R24: gain setup upper bits read zero
`timescale 1ns/1ps
`default_nettype none
module cgp_ctrl
(
  input  wire logic        clk,             // output clock, 25 MHz
  input  wire logic        sys_rst,         // async reset, active high
  input  wire logic [3:0]  host_addr,       // host word address
  input  wire logic [15:0] host_wdata,      // host write data
  input  wire logic        host_wr,         // host write strobe
  input  wire logic        host_low_word_wr,// write to a frequency low word
  input  wire logic [1:0]  chan_id,         // channel number 0..3
  input  wire logic        ext_gate,        // external transmit gate
  input  wire logic        int_gate,        // internally generated gate
  input  wire logic        hw_update,       // hardware update input
  input  wire logic        par_mode,        // parallel input mode
  input  wire logic        fifo_ovf,        // fifo overflow event
  input  wire logic        ramp_step,       // advance ramp address
  input  wire logic        ramp_dir_up,     // ramp direction
  input  wire logic [15:0] ramp_gain_in,    // gain value from ramp RAM
  input  wire logic        four_ch_real,    // four-channel real output mode
  input  wire logic [15:0] sum_re,          // default output sample
  input  wire logic [15:0] sum_im,          // complex alternative sample
  input  wire logic [15:0] fir_iq,          // I/Q after shaping filter
  input  wire logic        coarse_tick,     // half coarse sample strobe
  output logic [15:0]      host_rdata,      // host read data
  output logic             slave_load,      // load selected slave regs
  output logic             transmit_gate,   // aligned gate into channel
  output logic [6:0]       ramp_addr,       // gain profile RAM address
  output logic [15:0]      ramp_gain,       // gain value to datapath
  output logic             ramp_host_acc,   // host owns ramp RAM
  output logic             coef_host_acc,   // host owns coefficient RAMs
  output logic [2:0]       ae_threshold,    // almost-empty depth
  output logic             fifo_rd_zero,    // force fifo read address 0
  output logic             channel_flush_done, // flush complete status
  output logic             flush_active,    // flush channel and FIR RAM
  output logic             chan_reset,      // channel reset on overflow
  output logic             sib_run,         // serial_input_block enable
  output logic             serial_req_en,   // serial requests permitted
  output logic [15:0]      iq_out,          // delayed I/Q path
  output logic [15:0]      chan_out         // channel output data
);
  import cgp_pkg::*;

  logic [15:0] gain_r, gain_nxt, main_r, main_nxt;
  logic [GATE_DLY_LEN-1:0] gdly_r, gdly_nxt;
  logic        gate_sel, gate_in, gate_q_r, gate_q_nxt, sw_q_r, sw_q_nxt;
  logic [4:0]  flush_cnt_r, flush_cnt_nxt;
  logic [2:0]  imm_cnt_r, imm_cnt_nxt;
  logic [6:0]  addr_r, addr_nxt;
  logic [15:0] gain_hold_r, gain_hold_nxt, iq_d_r, iq_d_nxt;
  logic [15:0] rdata_nxt, out_nxt, iq_nxt;
  logic        load_nxt, gate_nxt, rst_nxt, done_r, done_nxt;
  logic        gate_rise, sw_rise;

  // register writes; only the documented bits are stored
  always_comb
  begin
    gain_nxt = gain_r;
    main_nxt = main_r;
    if (host_wr && host_addr == ADDR_GAIN_RAMP)
      gain_nxt = host_wdata & GATE_MASK_F(); // see R24
    if (host_wr && host_addr == ADDR_MAIN_CTRL)
      main_nxt = host_wdata;
    rdata_nxt = 16'h0000;
    if (host_addr == ADDR_GAIN_RAMP)
      rdata_nxt = gain_r;
    else if (host_addr == ADDR_MAIN_CTRL)
      rdata_nxt = main_r;
  end

  function automatic logic [15:0] GATE_MASK_F();
    return GAIN_RAMP_MASK;
  endfunction : GATE_MASK_F

  // gate source, input enable and latency alignment
  always_comb
  begin
    gate_sel = main_r[GATE_INT_BIT] ? int_gate : ext_gate; // see R11
    gate_in  = gate_sel & main_r[IN_EN_BIT]; // see R15
    gdly_nxt = {gdly_r[GATE_DLY_LEN-2:0], gate_in};
    if (gain_r[LAT_BYPASS_BIT])
      gate_nxt = gate_in; // see R2
    else if (gain_r[LAT_TWO_BIT])
      gate_nxt = gdly_r[GATE_DLY_SHORT-1]; // see R1
    else
      gate_nxt = gdly_r[GATE_DLY_LEN-1];
    gate_q_nxt = gate_nxt;
    sw_q_nxt   = main_r[SW_TX_BIT];
  end

  assign gate_rise = gate_nxt & ~gate_q_r;
  assign sw_rise   = main_r[SW_TX_BIT] & ~sw_q_r;

  // flush timer, update strobes and immediate sync counter
  always_comb
  begin
    flush_cnt_nxt = (flush_cnt_r != 5'd0) ? flush_cnt_r - 5'd1 : 5'd0;
    if (sw_rise || (gate_rise && !main_r[FLUSH_DIS_BIT])) // see R19
      flush_cnt_nxt = FLUSH_CYCLES; // see R21
    imm_cnt_nxt = (imm_cnt_r != 3'd0) ? imm_cnt_r - 3'd1 : 3'd0;
    if (main_r[IMM_UPD_BIT] && (host_low_word_wr || (host_wr && host_addr != 4'h0))) // see R23
      imm_cnt_nxt = IMM_SYNC_CYCLES; // see R6
    load_nxt = sw_rise || (hw_update && main_r[IN_EN_BIT] && !main_r[IMM_UPD_BIT]) // see R5
               || (imm_cnt_r == 3'd1);
    rst_nxt  = fifo_ovf && par_mode && !main_r[OVF_DIS_BIT]; // see R20
    done_nxt = !main_r[ONLINE_BIT] && (done_r || flush_cnt_r == 5'd1 || flush_cnt_r == 5'd0); // see R14
  end

  // ramp address and gain with hold
  always_comb
  begin
    addr_nxt      = addr_r;
    gain_hold_nxt = gain_hold_r;
    if (!main_r[RAMP_HOLD_BIT]) // see R7
    begin
      gain_hold_nxt = ramp_gain_in;
      if (ramp_step && ramp_dir_up && addr_r < gain_r[RAMP_LEN_MSB:0])
        addr_nxt = addr_r + 7'd1; // see R4
      else if (ramp_step && !ramp_dir_up && addr_r != 7'd0)
        addr_nxt = addr_r - 7'd1;
      if (addr_nxt > gain_r[RAMP_LEN_MSB:0])
        addr_nxt = gain_r[RAMP_LEN_MSB:0]; // see R4
    end
  end

  // data path: half sample delay, complex swap, output gate
  always_comb
  begin
    iq_d_nxt = coarse_tick ? fir_iq : iq_d_r;
    iq_nxt   = main_r[DLY_SEL_BIT] ? iq_d_r : fir_iq; // see R9
    out_nxt  = sum_re;
    if (main_r[CPLX_OUT_BIT] && four_ch_real && !chan_id[0])
      out_nxt = sum_im; // see R13
    if (!main_r[OUT_EN_BIT])
      out_nxt = 16'h0000; // see R16
  end

  // all state registers
  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      gain_r <= GAIN_RAMP_RST;
      main_r <= MAIN_CTRL_RST;
      gdly_r <= '0;
      gate_q_r <= 1'b0;
      sw_q_r <= 1'b0;
      flush_cnt_r <= 5'd0;
      imm_cnt_r <= 3'd0;
      addr_r <= 7'd0;
      gain_hold_r <= 16'h0000;
      iq_d_r <= 16'h0000;
      done_r <= 1'b0;
      host_rdata <= 16'h0000;
      slave_load <= 1'b0;
      transmit_gate <= 1'b0;
      ramp_addr <= 7'd0;
      ramp_gain <= 16'h0000;
      ramp_host_acc <= 1'b0;
      coef_host_acc <= 1'b0;
      ae_threshold <= 3'd0;
      fifo_rd_zero <= 1'b1;
      channel_flush_done <= 1'b0;
      flush_active <= 1'b0;
      chan_reset <= 1'b0;
      sib_run <= 1'b0;
      serial_req_en <= 1'b0;
      iq_out <= 16'h0000;
      chan_out <= 16'h0000;
    end
    else
    begin
      gain_r <= gain_nxt;
      main_r <= main_nxt;
      gdly_r <= gdly_nxt;
      gate_q_r <= gate_q_nxt;
      sw_q_r <= sw_q_nxt;
      flush_cnt_r <= flush_cnt_nxt;
      imm_cnt_r <= imm_cnt_nxt;
      addr_r <= addr_nxt;
      gain_hold_r <= gain_hold_nxt;
      iq_d_r <= iq_d_nxt;
      done_r <= done_nxt;
      host_rdata <= rdata_nxt;
      slave_load <= load_nxt;
      transmit_gate <= gate_nxt;
      ramp_addr <= addr_nxt;
      ramp_gain <= gain_hold_nxt;
      ramp_host_acc <= main_nxt[RAMP_HOLD_BIT]; // see R7
      coef_host_acc <= main_nxt[COEF_HOLD_BIT]; // see R10
      ae_threshold <= main_nxt[AE_THR_MSB:AE_THR_LSB]; // see R12
      fifo_rd_zero <= !main_nxt[ONLINE_BIT]; // see R14
      channel_flush_done <= done_nxt;
      flush_active <= (flush_cnt_nxt != 5'd0);
      chan_reset <= rst_nxt;
      sib_run <= main_nxt[SIB_FREE_BIT] | gate_nxt; // see R17
      serial_req_en <= main_nxt[SW_TX_BIT]; // see R22
      iq_out <= iq_nxt;
      chan_out <= out_nxt;
    end
  end

  // checks
  chk_flush_len: assert property (@(posedge clk) disable iff (sys_rst)
    $rose(sw_q_r) |-> flush_active [*8]) else $error("flush too short"); // see R21
  chk_ramp_bound: assert property (@(posedge clk) disable iff (sys_rst)
    !main_r[RAMP_HOLD_BIT] |-> ##1 addr_r <= $past(gain_r[RAMP_LEN_MSB:0]))
    else $error("ramp past length"); // see R4
  chk_out_zero: assert property (@(posedge clk) disable iff (sys_rst)
    !main_r[OUT_EN_BIT] |=> chan_out == 16'h0000) else $error("output not zeroed"); // see R16
  chk_bypass_gate: assert property (@(posedge clk) disable iff (sys_rst)
    gain_r[LAT_BYPASS_BIT] |=> transmit_gate == $past(gate_in)) else $error("bypass wrong"); // see R2
  chk_hold_freeze: assert property (@(posedge clk) disable iff (sys_rst)
    main_r[RAMP_HOLD_BIT] && $past(main_r[RAMP_HOLD_BIT]) |-> $stable(addr_r))
    else $error("ramp moved in hold"); // see R7
  chk_ovf_reset: assert property (@(posedge clk) disable iff (sys_rst)
    fifo_ovf && !par_mode |=> !chan_reset) else $error("overflow reset outside parallel"); // see R20
  chk_upd_read: assert property (@(posedge clk) disable iff (sys_rst)
    host_addr == ADDR_GAIN_RAMP |=> host_rdata[15:9] == 7'd0) else $error("upper bits set"); // see R24
  chk_req_level: assert property (@(posedge clk) disable iff (sys_rst)
    !main_r[SW_TX_BIT] |-> !serial_req_en) else $error("request while disabled"); // see R22

  // gate path: shortened alignment, source select and input enable
  chk_short_gate: assert property (@(posedge clk) disable iff (sys_rst) // see R1
    gain_r[LAT_TWO_BIT] && !gain_r[LAT_BYPASS_BIT] |=> transmit_gate == $past(gdly_r[GATE_DLY_SHORT-1]))
    else $error("short gate path wrong");
  chk_gate_ext: assert property (@(posedge clk) disable iff (sys_rst) // see R11
    !main_r[GATE_INT_BIT] && main_r[IN_EN_BIT] && gain_r[LAT_BYPASS_BIT] |=> transmit_gate == $past(ext_gate))
    else $error("external gate not used");
  chk_gate_int: assert property (@(posedge clk) disable iff (sys_rst) // see R11
    main_r[GATE_INT_BIT] && main_r[IN_EN_BIT] && gain_r[LAT_BYPASS_BIT] |=> transmit_gate == $past(int_gate))
    else $error("internal gate not used");
  chk_in_gate: assert property (@(posedge clk) disable iff (sys_rst) // see R15
    !main_r[IN_EN_BIT] && gain_r[LAT_BYPASS_BIT] |=> !transmit_gate)
    else $error("gate accepted while input disabled");

  // flush starts on a gate edge or a software enable edge
  chk_gate_flush: assert property (@(posedge clk) disable iff (sys_rst) // see R19
    gate_rise && !main_r[FLUSH_DIS_BIT] |=> flush_active)
    else $error("gate edge did not flush");
  chk_flush_off: assert property (@(posedge clk) disable iff (sys_rst) // see R19
    main_r[FLUSH_DIS_BIT] && !sw_rise && flush_cnt_r == 5'd0 |=> !flush_active)
    else $error("flush while disabled");
  chk_sw_update: assert property (@(posedge clk) disable iff (sys_rst) // see R21
    sw_rise |=> slave_load)
    else $error("software edge did not update");

  // immediate load: strobe, four quiet cycles, then one load pulse
  sequence imm_strobe_seq;
    main_r[IMM_UPD_BIT] && host_low_word_wr;
  endsequence
  sequence imm_quiet_seq;
    (!host_wr && !host_low_word_wr) [*4];
  endsequence
  chk_imm_load: assert property (@(posedge clk) disable iff (sys_rst) // see R6 see R23
    imm_strobe_seq ##1 imm_quiet_seq |=> slave_load)
    else $error("immediate load missing");
  chk_sync_load: assert property (@(posedge clk) disable iff (sys_rst) // see R5
    !main_r[IMM_UPD_BIT] && main_r[IN_EN_BIT] && hw_update |=> slave_load)
    else $error("sync update missing");

  // control outputs track the stored word
  chk_offline_zero: assert property (@(posedge clk) disable iff (sys_rst) // see R14
    !main_r[ONLINE_BIT] |-> fifo_rd_zero)
    else $error("offline read not forced");
  chk_thresh_copy: assert property (@(posedge clk) disable iff (sys_rst) // see R12
    1'b1 |-> ae_threshold == main_r[AE_THR_MSB:AE_THR_LSB])
    else $error("threshold mismatch");
  chk_coef_hold: assert property (@(posedge clk) disable iff (sys_rst) // see R10
    1'b1 |-> coef_host_acc == main_r[COEF_HOLD_BIT])
    else $error("coefficient hold mismatch");
  chk_sib_free: assert property (@(posedge clk) disable iff (sys_rst) // see R17
    main_r[SIB_FREE_BIT] |-> sib_run)
    else $error("serial block stopped while free");

  // data path selections
  chk_delay_sel: assert property (@(posedge clk) disable iff (sys_rst) // see R9
    main_r[DLY_SEL_BIT] |=> iq_out == $past(iq_d_r))
    else $error("delayed path not used");
  chk_cplx_swap: assert property (@(posedge clk) disable iff (sys_rst) // see R13
    main_r[CPLX_OUT_BIT] && main_r[OUT_EN_BIT] && four_ch_real && !chan_id[0] |=> chan_out == $past(sum_im))
    else $error("complex swap missing");
  chk_ovf_on: assert property (@(posedge clk) disable iff (sys_rst) // see R20
    fifo_ovf && par_mode && !main_r[OVF_DIS_BIT] |=> chan_reset)
    else $error("overflow reset missing");
  chk_gain_follow: assert property (@(posedge clk) disable iff (sys_rst) // see R7
    !main_r[RAMP_HOLD_BIT] |=> ramp_gain == $past(ramp_gain_in))
    else $error("ramp gain not following");
endmodule : cgp_ctrl
`default_nettype wire

// ---- verilog/cgp_pkg.sv ----
package cgp_pkg;
  // register word addresses on the host parallel bus
  localparam logic [3:0]  ADDR_GAIN_RAMP   = 4'hb;
  localparam logic [3:0]  ADDR_MAIN_CTRL   = 4'hc;
  localparam logic [15:0] GAIN_RAMP_RST    = 16'h0000;
  localparam logic [15:0] MAIN_CTRL_RST    = 16'h0000;
  localparam logic [15:0] GAIN_RAMP_MASK   = 16'h01ff;
  // gain ramp setup fields
  localparam int LAT_TWO_BIT    = 7;
  localparam int LAT_BYPASS_BIT = 8;
  localparam int RAMP_LEN_MSB   = 6;
  // main control fields
  localparam int IMM_UPD_BIT    = 15;
  localparam int RAMP_HOLD_BIT  = 14;
  localparam int DLY_SEL_BIT    = 13;
  localparam int COEF_HOLD_BIT  = 12;
  localparam int GATE_INT_BIT   = 11;
  localparam int AE_THR_MSB     = 10;
  localparam int AE_THR_LSB     = 8;
  localparam int CPLX_OUT_BIT   = 7;
  localparam int ONLINE_BIT     = 6;
  localparam int IN_EN_BIT      = 5;
  localparam int OUT_EN_BIT     = 4;
  localparam int SIB_FREE_BIT   = 3;
  localparam int FLUSH_DIS_BIT  = 2;
  localparam int OVF_DIS_BIT    = 1;
  localparam int SW_TX_BIT      = 0;
  // timing in output clock cycles
  localparam logic [4:0] FLUSH_CYCLES   = 5'd16;
  localparam logic [2:0] IMM_SYNC_CYCLES = 3'd4;
  // gate delay line length; two stages are dropped in short mode
  localparam int GATE_DLY_LEN   = 4;
  localparam int GATE_DLY_SHORT = 2;
endpackage : cgp_pkg
